// ### logic/oam_params.svh
// timing figures and mode encodings for the operand address mode unit
`ifndef OAM_PARAMS_SVH
`define OAM_PARAMS_SVH

`define OAM_CLK_NS 50

// addressing mode codes (3-bit mode field)
`define OAM_MODE_REG 3'h0
`define OAM_MODE_REGDEF 3'h1
`define OAM_MODE_AUTOINC 3'h2
`define OAM_MODE_AUTOINC_DEF 3'h3
`define OAM_MODE_AUTODEC 3'h4
`define OAM_MODE_AUTODEC_DEF 3'h5
`define OAM_MODE_INDEX 3'h6
`define OAM_MODE_INDEX_DEF 3'h7

// register numbers with special behaviour
`define OAM_SP_REG 3'h6
`define OAM_PC_REG 3'h7

// instruction field positions
`define OAM_BYTE_BIT 15
`define OAM_SRC_LSB 6
`define OAM_DST_LSB 0

// step sizes
`define OAM_WORD_STEP 16'h0002
`define OAM_BYTE_STEP 16'h0001

// operand access times in ns
`define OAM_SRC_T1_NS 1500
`define OAM_SRC_T2_NS 2700
`define OAM_SRC_T3_NS 3900
`define OAM_DST_SAVE_NS 100
`define OAM_NOWB_SAVE_NS 500
`define OAM_ODD_BYTE_NS 600

`endif

// ### logic/oam_pkg.sv
// types for the operand address mode unit
package oam_pkg;
    typedef enum logic [1:0] {
        OAM_IDLE = 2'b00,
        OAM_EXT = 2'b01,
        OAM_PTR = 2'b11,
        OAM_WAIT = 2'b10
    } oam_state_e;
endpackage

// ### logic/oam_operand_address_mode_unit.sv
// operand address generation for one source or destination field
//
// Function
// [RQ1] mode 000 operand is the register; mode 001 register holds operand address
// [RQ2] mode 010 register is the address, then register steps up
// [RQ3] mode 100 register steps down first, new value is the address
// [RQ4] mode 110 fetch offset word, add register, neither changes
// [RQ5] mode 011 read pointer at register, then register plus two always
// [RQ6] mode 101 register minus two always, then read pointer there
// [RQ7] mode 111 offset plus register addresses a pointer word, nothing changes
// [RQ8] index with register seven adds extension word to updated program counter
// [RQ9] index deferred with register seven: counter plus word addresses pointer
// [RQ10] stack pointer auto steps are always two, even for bytes
// [RQ11] opcode bit 15 set marks a byte instruction
// [RQ12] execution time is basic time plus source and destination access time
// [RQ13] source access times 0, 1.5, 2.7, 3.9 us by mode
// [RQ14] destination 0.1 us less; compare and test save 0.5 us more
// [RQ15] byte operand at odd address adds 0.6 us
// [RQ16] every program counter word fetch advances it by two
// [RQ17] immediate is autoincrement on the program counter
// [RQ18] absolute is autoincrement deferred on the program counter
// [RQ19] relative modes add the counter value after the offset fetch
`timescale 1ns/1ns
`include "oam_params.svh"

module oam_operand_address_mode_unit
    import oam_pkg::*;
#(
    parameter int DATA_W = 16,
    parameter int CNT_W = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic [DATA_W-1:0] instr,
    input wire logic isDest,
    input wire logic noWriteback,
    input wire logic regWe,
    input wire logic [2:0] regWsel,
    input wire logic [DATA_W-1:0] regWdata,
    input wire logic [2:0] rdSel,
    output logic [DATA_W-1:0] rdData,
    output logic memReq,
    output logic [DATA_W-1:0] memAddr,
    input wire logic memAck,
    input wire logic [DATA_W-1:0] memRdata,
    output logic busy,
    output logic done,
    output logic byteOp,
    output logic operandIsReg,
    output logic [2:0] operandReg,
    output logic [DATA_W-1:0] operandAddr,
    output logic [CNT_W-1:0] accessCycles
);

    oam_state_e state;
    logic [2:0] mode;
    logic [CNT_W-1:0] cycleCount;
    logic [DATA_W-1:0] regs [0:7];
    logic isDestLatched;
    logic noWbLatched;

    // least times, so round up to whole cycles
    function automatic logic [CNT_W-1:0] nsToCycles(input int ns);
        int c;
        c = (ns + `OAM_CLK_NS - 1) / `OAM_CLK_NS;
        return CNT_W'(c);
    endfunction

    function automatic int accessNs(input logic [2:0] m, input logic dst, input logic noWb, input logic oddByte);
        int ns;
        case (m)
            `OAM_MODE_REG: ns = 0;
            `OAM_MODE_REGDEF: ns = `OAM_SRC_T1_NS;
            `OAM_MODE_AUTOINC: ns = `OAM_SRC_T1_NS;
            `OAM_MODE_AUTODEC: ns = `OAM_SRC_T1_NS;
            `OAM_MODE_AUTOINC_DEF: ns = `OAM_SRC_T2_NS;
            `OAM_MODE_AUTODEC_DEF: ns = `OAM_SRC_T2_NS;
            `OAM_MODE_INDEX: ns = `OAM_SRC_T2_NS;
            `OAM_MODE_INDEX_DEF: ns = `OAM_SRC_T3_NS;
            default: ns = `OAM_SRC_T3_NS;
        endcase // [RQ13]
        if (dst && ns != 0) begin
            ns = ns - `OAM_DST_SAVE_NS; // [RQ14]
            if (noWb) begin
                ns = ns - `OAM_NOWB_SAVE_NS; // [RQ14]
            end
        end
        if (oddByte) begin
            ns = ns + `OAM_ODD_BYTE_NS; // [RQ15]
        end
        return ns;
    endfunction

    logic [2:0] fieldMode;
    logic [2:0] fieldReg;
    logic isByte;
    logic [DATA_W-1:0] selVal;
    logic [DATA_W-1:0] pcVal;
    logic [DATA_W-1:0] step;
    logic [DATA_W-1:0] extSum;
    logic [CNT_W-1:0] budget;
    logic take;

    // six-bit mode and register field of the chosen operand
    function automatic logic [5:0] fieldOf(input logic [DATA_W-1:0] word, input logic dst);
        if (dst) begin
            return word[`OAM_DST_LSB+5:`OAM_DST_LSB];
        end
        return word[`OAM_SRC_LSB+5:`OAM_SRC_LSB];
    endfunction

    always_comb begin
        {fieldMode, fieldReg} = fieldOf(instr, isDest);
        isByte = instr[`OAM_BYTE_BIT]; // [RQ11]
        // take only while idle; a start while busy is dropped
        take = start && state == OAM_IDLE;
        selVal = regs[fieldReg];
        pcVal = regs[`OAM_PC_REG];
        // stack pointer and program counter never take odd steps
        if (isByte && fieldReg != `OAM_SP_REG && fieldReg != `OAM_PC_REG) begin
            step = `OAM_BYTE_STEP;
        end else begin
            step = `OAM_WORD_STEP; // [RQ10] [RQ16]
        end
        // the counter was already advanced past the offset word here
        extSum = DATA_W'(regs[operandReg] + memRdata); // [RQ8] [RQ9] [RQ19]
        budget = nsToCycles(accessNs(mode, isDestLatched, noWbLatched,
                                     byteOp && operandAddr[0] && mode != `OAM_MODE_REG));
    end

    // operand descriptor latched at take, stands until the next take
    always_ff @(posedge clk) begin
        if (rst) begin
            mode <= `OAM_MODE_REG;
            operandReg <= 3'h0;
            byteOp <= 1'b0;
            isDestLatched <= 1'b0;
            noWbLatched <= 1'b0;
            operandIsReg <= 1'b0;
        end else if (take) begin
            mode <= fieldMode;
            operandReg <= fieldReg;
            byteOp <= isByte; // [RQ11]
            isDestLatched <= isDest;
            noWbLatched <= noWriteback;
            operandIsReg <= (fieldMode == `OAM_MODE_REG); // [RQ1]
        end
    end

    // completion: done pulses once, busy covers take to done
    always_ff @(posedge clk) begin
        if (rst) begin
            busy <= 1'b0;
            done <= 1'b0;
            accessCycles <= '0;
        end else begin
            done <= 1'b0;
            if (take) begin
                busy <= 1'b1;
            end
            if (state == OAM_WAIT && cycleCount >= budget) begin
                accessCycles <= cycleCount; // [RQ12]
                done <= 1'b1;
                busy <= 1'b0;
            end
        end
    end

    // sequencing and register updates share one process: the array has one writer
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= OAM_IDLE;
            operandAddr <= '0;
            memReq <= 1'b0;
            memAddr <= '0;
            for (int i = 0; i < 8; i++) begin
                regs[i] <= '0;
            end
        end else begin
            case (state)
                OAM_IDLE: begin
                    // outside writes only while idle; the unit's own update wins a tie
                    if (regWe) begin
                        regs[regWsel] <= regWdata;
                    end
                    if (take) begin
                        case (fieldMode)
                            `OAM_MODE_REG: begin
                                // operand is the register itself, no address
                                state <= OAM_WAIT; // [RQ1]
                            end

                            `OAM_MODE_REGDEF: begin
                                // register already holds the address
                                operandAddr <= selVal; // [RQ1]
                                state <= OAM_WAIT;
                            end

                            `OAM_MODE_AUTOINC: begin
                                // immediate when the register is the counter
                                operandAddr <= selVal; // [RQ2] [RQ17]
                                regs[fieldReg] <= DATA_W'(selVal + step); // [RQ2] [RQ10] [RQ16]
                                state <= OAM_WAIT;
                            end

                            `OAM_MODE_AUTODEC: begin
                                // decrement lands before the address is used
                                operandAddr <= DATA_W'(selVal - step); // [RQ3]
                                regs[fieldReg] <= DATA_W'(selVal - step); // [RQ3] [RQ10]
                                state <= OAM_WAIT;
                            end

                            `OAM_MODE_AUTOINC_DEF: begin
                                // absolute when the register is the counter
                                memReq <= 1'b1;
                                memAddr <= selVal; // [RQ5] [RQ18]
                                regs[fieldReg] <= DATA_W'(selVal + `OAM_WORD_STEP); // [RQ5]
                                state <= OAM_PTR;
                            end

                            `OAM_MODE_AUTODEC_DEF: begin
                                // step is a word even for byte operands
                                memReq <= 1'b1;
                                memAddr <= DATA_W'(selVal - `OAM_WORD_STEP); // [RQ6]
                                regs[fieldReg] <= DATA_W'(selVal - `OAM_WORD_STEP); // [RQ6]
                                state <= OAM_PTR;
                            end

                            `OAM_MODE_INDEX, `OAM_MODE_INDEX_DEF: begin
                                // index modes: offset word follows the instruction
                                memReq <= 1'b1;
                                memAddr <= pcVal; // [RQ4] [RQ7]
                                regs[`OAM_PC_REG] <= DATA_W'(pcVal + `OAM_WORD_STEP); // [RQ16]
                                state <= OAM_EXT;
                            end

                            default: begin
                                // unreachable: all eight codes decoded above
                                state <= OAM_WAIT;
                            end
                        endcase
                    end
                end

                OAM_EXT: begin
                    // offset word arrives in the acknowledge cycle
                    if (memAck) begin
                        if (mode == `OAM_MODE_INDEX_DEF) begin
                            // request stays up: pointer read follows back to back
                            memAddr <= extSum; // [RQ7] [RQ9]
                            state <= OAM_PTR;
                        end else begin
                            memReq <= 1'b0;
                            operandAddr <= extSum; // [RQ4] [RQ8]
                            state <= OAM_WAIT;
                        end
                    end
                end

                OAM_PTR: begin
                    // pointer word holds the operand address
                    if (memAck) begin
                        memReq <= 1'b0;
                        operandAddr <= memRdata; // [RQ5] [RQ6] [RQ7]
                        state <= OAM_WAIT;
                    end
                end

                OAM_WAIT: begin
                    // stretch to the mode's access time so execution time adds up
                    if (cycleCount >= budget) begin
                        state <= OAM_IDLE; // [RQ12]
                    end
                end

                default: begin
                    state <= OAM_IDLE;
                end
            endcase
        end
    end

    // cycles since start; saturates so a stuck memory cannot wrap the budget check
    always_ff @(posedge clk) begin
        if (rst || state == OAM_IDLE) begin
            cycleCount <= '0;
        end else if (cycleCount != {CNT_W{1'b1}}) begin
            cycleCount <= CNT_W'(cycleCount + 1'b1); // [RQ13]
        end
    end

    // registered read port, one cycle behind rdSel
    always_ff @(posedge clk) begin
        if (rst) begin
            rdData <= '0;
        end else begin
            rdData <= regs[rdSel];
        end
    end

endmodule // oam_operand_address_mode_unit

// ### bench/oam_monitor.sv
// assertion checker on the operand address mode unit ports
`timescale 1ns/1ns
module oam_monitor #(
    parameter int DATA_W = 16,
    parameter int CNT_W = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic [DATA_W-1:0] instr,
    input wire logic isDest,
    input wire logic memReq,
    input wire logic [DATA_W-1:0] memAddr,
    input wire logic memAck,
    input wire logic busy,
    input wire logic done,
    input wire logic byteOp,
    input wire logic operandIsReg,
    input wire logic [DATA_W-1:0] operandAddr,
    input wire logic [CNT_W-1:0] accessCycles
);
    wire logic [2:0] mode = isDest ? instr[5:3] : instr[11:9];
    wire logic take = start && !busy;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_busy_on_take: assert property (take |=> busy) else $error("busy not raised");
    a_done_single: assert property (done |-> !busy ##1 !done) else $error("bad done pulse");
    a_byte_flag: assert property (take |=> byteOp == $past(instr[15])) else $error("byte flag");
    a_reg_no_mem: assert property (take && mode == 3'h0 |=> !memReq [*2]) else $error("reg read");
    a_direct_no_mem: assert property (take && (mode == 3'h1 || mode == 3'h2 || mode == 3'h4)
        |=> !memReq [*3]) else $error("direct read");
    a_fetch_starts: assert property (take && mode > 3'h2 && mode != 3'h4 |-> ##[1:2] memReq)
        else $error("no fetch");
    a_req_hold: assert property (memReq && !memAck |=> memReq && $stable(memAddr))
        else $error("request dropped");
    a_reg_time: assert property (done && operandIsReg |-> accessCycles == 0) else $error("reg time");
    a_min_time: assert property (done && !operandIsReg |-> accessCycles >= 18) else $error("short time");
    a_odd_byte: assert property (done && byteOp && !operandIsReg && operandAddr[0] |-> accessCycles >= 30)
        else $error("odd byte time");
    c_reg: cover property (take && mode == 3'h0);
    c_index_def: cover property (take && mode == 3'h7);
    c_odd: cover property (done && byteOp && operandAddr[0]);
endmodule // oam_monitor

bind oam_operand_address_mode_unit oam_monitor #(.DATA_W(DATA_W), .CNT_W(CNT_W)) oam_monitor_inst(
    .clk(clk), .rst(rst), .start(start), .instr(instr), .isDest(isDest), .memReq(memReq),
    .memAddr(memAddr), .memAck(memAck), .busy(busy), .done(done), .byteOp(byteOp),
    .operandIsReg(operandIsReg), .operandAddr(operandAddr), .accessCycles(accessCycles));

// ### bench/oam_mem_model.sv
// memory partner answering word reads after a set latency
`timescale 1ns/1ns
module oam_mem_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic memReq,
    input wire logic [15:0] memAddr,
    input wire logic [2:0] lat,
    output logic memAck,
    output logic [15:0] memRdata
);
    int cnt;
    // data is inverted outside the ack cycle so stale values never match
    assign memRdata = memAck ? memAddr ^ 16'h5a5b : ~(memAddr ^ 16'h5a5b);
    always_ff @(posedge clk) begin
        if (rst || !memReq || memAck) begin
            cnt <= 0;
            memAck <= 1'b0;
        end else if (cnt >= lat) begin
            memAck <= 1'b1;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule // oam_mem_model

// ### bench/tb.sv
// self-checking bench for the operand address mode unit
`timescale 1ns/1ns
module tb;
    logic clk, rst, start, isDest, noWriteback, regWe, memReq, memAck, busy, done, byteOp, operandIsReg;
    logic [15:0] instr, regWdata, rdData, memAddr, memRdata, operandAddr;
    logic [2:0] regWsel, rdSel, operandReg, lat;
    logic [7:0] accessCycles;
    logic [15:0] rm[8];
    int mismatches, checks_done, cyc;
    oam_operand_address_mode_unit oam_operand_address_mode_unit_inst(.clk(clk), .rst(rst), .start(start),
        .instr(instr), .isDest(isDest), .noWriteback(noWriteback), .regWe(regWe), .regWsel(regWsel),
        .regWdata(regWdata), .rdSel(rdSel), .rdData(rdData), .memReq(memReq), .memAddr(memAddr),
        .memAck(memAck), .memRdata(memRdata), .busy(busy), .done(done), .byteOp(byteOp),
        .operandIsReg(operandIsReg), .operandReg(operandReg), .operandAddr(operandAddr),
        .accessCycles(accessCycles));
    oam_mem_model oam_mem_model_inst(.clk(clk), .rst(rst), .memReq(memReq), .memAddr(memAddr), .lat(lat),
        .memAck(memAck), .memRdata(memRdata));
    initial begin
        clk = 0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            mismatches++;
            finish_test();
        end
    end
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task chkregs;
        for (int i = 0; i < 8; i++) begin
            @(posedge clk) rdSel <= 3'(i);
            repeat (2) @(posedge clk);
            chk(rdData, rm[i]);
        end
    endtask
    task op(input logic [2:0] m, input logic [2:0] r, input logic b, input logic d, input logic nwb,
        input logic hold);
        logic [15:0] a, x;
        logic [8:0] f;
        int ns, n, st;
        st = (b && r < 6) ? 1 : 2;
        f = 9'($urandom);
        if (m == 3'h4) rm[r] = rm[r] - 16'(st);
        if (m == 3'h5) rm[r] = rm[r] - 16'h0002;
        x = rm[7] ^ 16'h5a5b;
        if (m >= 3'h6) rm[7] = rm[7] + 16'h0002;
        a = (m >= 3'h6) ? rm[r] + x : rm[r];
        if (m == 3'h3 || m == 3'h5 || m == 3'h7) a = a ^ 16'h5a5b;
        if (m == 3'h2) rm[r] = rm[r] + 16'(st);
        if (m == 3'h3) rm[r] = rm[r] + 16'h0002;
        case (m)
            3'h0: ns = 0;
            3'h1, 3'h2, 3'h4: ns = 1500;
            3'h3, 3'h5, 3'h6: ns = 2700;
            default: ns = 3900;
        endcase
        if (d && ns > 0) ns -= nwb ? 600 : 100;
        if (b && m != 3'h0 && a[0]) ns += 600;
        @(posedge clk);
        instr <= d ? {b, f, m, r} : {b, f[2:0], m, r, f[8:3]};
        isDest <= d;
        noWriteback <= nwb;
        start <= 1'b1;
        lat <= 3'($urandom % 5);
        @(posedge clk);
        // repeated start and a write while busy must both be ignored
        start <= hold;
        regWe <= 1'b1;
        regWsel <= r;
        regWdata <= ~rm[r];
        @(posedge clk);
        start <= 1'b0;
        regWe <= 1'b0;
        n = 0;
        do @(negedge clk); while (done !== 1'b1 && ++n < 400);
        chk(operandIsReg, m == 3'h0);
        chk(operandReg, r);
        chk(byteOp, b);
        if (m != 3'h0) chk(operandAddr, a);
        chk(accessCycles, 16'((ns + 49) / 50));
        chkregs();
    endtask
    initial begin
        {start, isDest, noWriteback, regWe, regWsel, regWdata, rdSel, instr, lat} = '0;
        rst = 1'b1;
        void'($urandom(11));
        for (int k = 0; k < 2; k++) begin
            @(posedge clk) rst <= 1'b1;
            repeat (16) @(posedge clk);
            rst <= 1'b0;
            for (int i = 0; i < 8; i++) rm[i] = 16'h0000;
            chkregs();
            for (int i = 0; i < 8; i++) begin
                @(posedge clk);
                regWe <= 1'b1;
                regWsel <= 3'(i);
                regWdata <= 16'($urandom) & 16'hfffe;
                @(posedge clk) regWe <= 1'b0;
                rm[i] = regWdata;
            end
            for (int t = 0; t < 48; t++)
                op(3'(t), 3'($urandom), 1'($urandom), 1'($urandom), 1'($urandom), t % 5 == 0);
            $display("test pass %0d ended", k);
        end
        finish_test();
    end
endmodule // tb
